// ### design/div_if.sv
// ratios and divided pulse between latch logic and the main divider
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`include "synth_params.svh"
interface div_if;
   logic [`N_W-1:0] n;
   logic [`A_W-1:0] a;
   logic sw;
   logic en;
   logic pulse;
   modport ctl (output n, a, sw, en, input pulse);
   modport div (input n, a, sw, en, output pulse);
endinterface

// ### design/pulse_swallow_div.sv
// pulse-swallow main divider: dual-modulus prescaler, swallow and main counters
// assumes clk stands in for the prescaler input, ratios come from div_if
`timescale 1ns/1ps
`include "synth_params.svh"
module pulse_swallow_div
(
   input wire logic clk, // system clock, counted as divider input
   input wire logic nrst, // synchronous reset, active low
   div_if.div d // ratios in, divided pulse out
);
   synth_pkg::div_t s, s_nxt;
   logic term;
   logic load;
   logic hv_r;
   logic [17:0] per_r;
   logic [17:0] exp_r;
   logic sw_r;

   // first prescaler count of one modulus cycle, plus one while swallowing
   function automatic logic [6:0] pre_top(input logic sw, input logic a_nz);
      pre_top = (sw ? `P_LO : `P_HI) + {6'h00, a_nz} - 7'h01;
   endfunction

   always_comb
   begin
      s_nxt = s;
      term = (s.pre == 7'h00);
      load = d.en && term && (s.nc <= 11'h001);
      s_nxt.pulse = 1'b0;
      if (!d.en)
      begin
         s_nxt.pre = 7'h00;
         s_nxt.nc = 11'h001;
         s_nxt.ac = '0;
      end
      else if (!term)
         s_nxt.pre = s.pre - 7'h01;
      else if (load)
      begin
         s_nxt.nc = d.n;
         s_nxt.ac = d.a;
         s_nxt.pulse = 1'b1;
         s_nxt.pre = pre_top(d.sw, d.a != '0);
      end
      else
      begin
         s_nxt.nc = s.nc - 11'h001;
         // swallowing ends before the main count, as a < n is kept
         s_nxt.ac = (s.ac != '0) ? s.ac - 7'h01 : 7'h00;
         s_nxt.pre = pre_top(d.sw, s_nxt.ac != '0);
      end
      if (!nrst)
      begin
         s_nxt = '0;
         s_nxt.nc = 11'h001;
      end
   end

   always_ff @(posedge clk)
   begin
      s <= s_nxt;
   end

   assign d.pulse = s.pulse;

   // period checker: cycles between loads against the loaded ratio
   always_ff @(posedge clk)
   begin
      if (!nrst)
         hv_r <= 1'b0;
      else if (load)
         hv_r <= 1'b1;
      // a select change inside a period mixes both moduli, so that period is skipped
      else if (!d.en || d.sw != sw_r)
         hv_r <= 1'b0;
      sw_r <= d.sw;
      per_r <= load ? 18'h00000 : per_r + 18'h00001;
      if (load)
         exp_r <= {11'h000, d.sw ? `P_LO : `P_HI} * {7'h00, d.n} + {11'h000, d.a};
   end

   total_ratio_a:
      assert property (@(posedge clk) disable iff (!nrst)
         load && hv_r && $stable(d.sw) |-> per_r + 18'h00001 == exp_r)
      else $error("main division differs from p*n+a");
   modulus_pick_a:
      assert property (@(posedge clk) disable iff (!nrst)
         d.en && term |=> s.pre + 7'h01 ==
            ($past(d.sw) ? `P_LO : `P_HI) + {6'h00, s.ac != 7'h00})
      else $error("prescaler modulus wrong for select bit");
   counter_load_a:
      assert property (@(posedge clk) disable iff (!nrst)
         load |=> s.pulse && s.nc == $past(d.n) && s.ac == $past(d.a))
      else $error("swallow or main counter not loaded");
   swallow_cov: cover property (@(posedge clk) disable iff (!nrst)
      load && d.a != '0 && d.sw);
endmodule // pulse_swallow_div

// ### design/synth_params.svh
// constants of the serial program latches and the dividers
// assumes inclusion by bare name from every design file
`ifndef SYNTH_PARAMS_SVH
`define SYNTH_PARAMS_SVH
`define SR_W 19
`define CTL_POS 0
`define SW_POS 1
`define R_LSB 2
`define R_W 14
`define REF_FRAME 16
`define A_LSB 1
`define A_W 7
`define N_LSB 8
`define N_W 11
`define R_RST 14'h0008
`define SW_RST 1'b0
`define N_RST 11'h010
`define A_RST 7'h00
`define EN_RST 1'b1
`define P_LO 7'h20
`define P_HI 7'h40
`define OFS_CTRL 4'h0
`define OFS_REF 4'h4
`define OFS_MAIN 4'h8
`define OFS_STAT 4'hc
`endif

// ### design/synth_pkg.sv
// types of the serial program latches and the dividers
// assumes synth_params.svh is on the include path
`include "synth_params.svh"
package synth_pkg;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SETTLE = 2'b01, ST_COPY = 2'b10} ld_st_t;
   typedef struct packed {
      logic [`SR_W-1:0] sr;
   } link_t;
   typedef struct packed {
      logic ls_s1;
      logic ls_s2;
      logic ps_s1;
      logic ps_s2;
      ld_st_t st;
      logic armed;
      logic en;
      logic sw;
      logic [`R_W-1:0] r;
      logic [`N_W-1:0] n;
      logic [`A_W-1:0] a;
      logic [`R_W-1:0] rcnt;
      logic rp;
      logic up;
      logic dn;
      logic mon;
      logic phr;
      logic php;
      logic pu;
      logic pd;
      logic aux;
      logic aux_oe_n;
      logic [31:0] rdata;
   } top_t;
   typedef struct packed {
      logic [6:0] pre;
      logic [`A_W-1:0] ac;
      logic [`N_W-1:0] nc;
      logic pulse;
   } div_t;
endpackage

// ### design/synth_serial_program_latches.sv
// serial programming front end: shift register, divider latches,
// reference divider, phase comparator and charge pump steering
// assumes sclk is the controller's shift clock and clk the reference
// oscillator; pads pull load_strobe and phase_sense_select high
//
// Behaviour
// - each rising sclk edge shifts one data bit into the shift register
// - while load strobe is high, shift register goes to the latch chosen
// - control bit high: only the 15-bit reference latch is loaded
// - control bit low: only the 18-bit main latch is loaded
// - a reference frame is 16 bits: ratio, prescaler select, control
// - prescaler select 0 divides 64/65, select 1 divides 32/33
// - strobe high connects second pump to switch pin, low floats it
// - monitor shows reference divider when phase select high, else main
// - phase select low inverts comparator outputs and pump drive
// - strobe and phase select read high when left open
// - main divider is 7-bit swallow and 11-bit main counter from latch
// - total feedback division is modulus times main ratio plus swallow
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "synth_params.svh"
module synth_serial_program_latches
(
   input wire logic clk, // 50 MHz reference clock
   input wire logic nrst, // synchronous reset, active low
   input wire logic sclk, // serial shift clock from the controller
   input wire logic sdata, // serial data, taken at rising sclk
   input wire logic load_strobe, // high: load the chosen latch
   input wire logic phase_sense_select, // high: normal phase sense
   input wire logic [3:0] addr, // register byte address
   input wire logic [31:0] wdata, // register write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd
   output logic comparator_monitor_out, // selected divided pulse
   output logic phase_r_out, // comparator output, reference side
   output logic phase_p_out, // comparator output, main side
   output logic pump_up_out, // charge pump source drive
   output logic pump_dn_out, // charge pump sink drive
   output logic aux_pump_switch_out, // second pump drive level
   output logic aux_pump_switch_oe_n // low while switch pin drives
);
   synth_pkg::link_t lk, lk_nxt;
   synth_pkg::top_t s, s_nxt;
   logic up_t;
   logic dn_t;
   logic main_pulse;
   logic sense_up;
   logic sense_dn;
   logic [`R_W-1:0] rgap_r;
   logic [`R_W-1:0] rexp_r;
   logic rvalid_r;

   div_if dif();

   // link domain: only the shift register lives on sclk
   always_comb
   begin
      lk_nxt.sr = {lk.sr[`SR_W-2:0], sdata};
   end

   always_ff @(posedge sclk)
   begin
      lk <= lk_nxt;
   end

   // system domain
   always_comb
   begin
      s_nxt = s;
      up_t = s.up | s.rp;
      dn_t = s.dn | main_pulse;
      s_nxt.ls_s1 = load_strobe;
      s_nxt.ls_s2 = s.ls_s1;
      s_nxt.ps_s1 = phase_sense_select;
      s_nxt.ps_s2 = s.ps_s1;
      // a load needs a low strobe first, so a whole frame was shifted
      s_nxt.armed = s.armed | ~s.ls_s2;

      // shift register is read only after the strobe has stood high two
      // cycles; the controller does not clock while the strobe is high
      case (s.st)
         synth_pkg::ST_IDLE:
         begin
            if (s.ls_s2 && s.armed)
               s_nxt.st = synth_pkg::ST_SETTLE;
         end
         synth_pkg::ST_SETTLE:
         begin
            s_nxt.st = s.ls_s2 ? synth_pkg::ST_COPY : synth_pkg::ST_IDLE;
         end
         synth_pkg::ST_COPY:
         begin
            if (!s.ls_s2)
               s_nxt.st = synth_pkg::ST_IDLE;
            else if (lk.sr[`CTL_POS])
            begin
               s_nxt.r = lk.sr[`REF_FRAME-1:`R_LSB];
               s_nxt.sw = lk.sr[`SW_POS];
            end
            else
            begin
               s_nxt.n = lk.sr[`N_LSB+`N_W-1:`N_LSB];
               s_nxt.a = lk.sr[`A_LSB+`A_W-1:`A_LSB];
            end
         end
         default:
         begin
            s_nxt.st = synth_pkg::ST_IDLE;
         end
      endcase

      // reference divider, one pulse every r cycles
      s_nxt.rp = 1'b0;
      if (!s.en)
         s_nxt.rcnt = '0;
      else if (s.rcnt == '0)
      begin
         s_nxt.rcnt = s.r - 14'h0001;
         s_nxt.rp = 1'b1;
      end
      else
         s_nxt.rcnt = s.rcnt - 14'h0001;

      // phase/frequency detector: first edge wins, both clear together
      if (!s.en || (up_t && dn_t))
      begin
         s_nxt.up = 1'b0;
         s_nxt.dn = 1'b0;
      end
      else
      begin
         s_nxt.up = up_t;
         s_nxt.dn = dn_t;
      end

      s_nxt.mon = s.ps_s2 ? s.rp : main_pulse;
      s_nxt.pu = sense_up;
      s_nxt.pd = sense_dn;
      s_nxt.php = ~sense_up;
      s_nxt.phr = sense_dn;
      s_nxt.aux = sense_up;
      s_nxt.aux_oe_n = ~s.ls_s2;

      // register port
      s_nxt.rdata = '0;
      if (wr && addr == `OFS_CTRL)
         s_nxt.en = wdata[0];
      if (rd)
      begin
         case (addr)
            `OFS_CTRL: s_nxt.rdata = {31'h00000000, s.en};
            `OFS_REF: s_nxt.rdata = {17'h00000, s.sw, s.r};
            `OFS_MAIN: s_nxt.rdata = {14'h0000, s.n, s.a};
            `OFS_STAT: s_nxt.rdata = {26'h0000000, s.st, s.ps_s2, s.ls_s2, s.dn, s.up};
            default: s_nxt.rdata = '0;
         endcase
      end

      if (!nrst)
      begin
         s_nxt = '0;
         s_nxt.ls_s1 = 1'b1;
         s_nxt.ls_s2 = 1'b1;
         s_nxt.ps_s1 = 1'b1;
         s_nxt.ps_s2 = 1'b1;
         s_nxt.st = synth_pkg::ST_IDLE;
         s_nxt.en = `EN_RST;
         s_nxt.r = `R_RST;
         s_nxt.sw = `SW_RST;
         s_nxt.n = `N_RST;
         s_nxt.a = `A_RST;
         s_nxt.php = 1'b1;
         s_nxt.aux_oe_n = 1'b1;
      end
   end

   // phase select low swaps the roles of the two detector flags
   assign sense_up = s.ps_s2 ? s.up : s.dn;
   assign sense_dn = s.ps_s2 ? s.dn : s.up;

   always_ff @(posedge clk)
   begin
      s <= s_nxt;
   end

   assign dif.n = s.n;
   assign dif.a = s.a;
   assign dif.sw = s.sw;
   assign dif.en = s.en;
   assign main_pulse = dif.pulse;

   pulse_swallow_div u_div
   (
      .clk(clk),
      .nrst(nrst),
      .d(dif)
   );

   assign rdata = s.rdata;
   assign comparator_monitor_out = s.mon;
   assign phase_r_out = s.phr;
   assign phase_p_out = s.php;
   assign pump_up_out = s.pu;
   assign pump_dn_out = s.pd;
   assign aux_pump_switch_out = s.aux;
   assign aux_pump_switch_oe_n = s.aux_oe_n;

   // reference period checker: cycles between reloads against the latched ratio
   always_ff @(posedge clk)
   begin
      if (!nrst || !s.en)
         rvalid_r <= 1'b0;
      else if (s.rcnt == '0)
         rvalid_r <= 1'b1;
      rgap_r <= (s.rcnt == '0) ? 14'h0000 : rgap_r + 14'h0001;
      if (s.rcnt == '0)
         rexp_r <= s.r;
   end

   ref_ratio_a:
      assert property (@(posedge clk) disable iff (!nrst)
         s.en && s.rcnt == '0 && rvalid_r |-> rgap_r + 14'h0001 == rexp_r)
      else $error("reference period differs from the latched ratio");

   shift_in_a:
      assert property (@(posedge sclk) disable iff (!nrst)
         1'b1 ##1 1'b1 |-> lk.sr[`CTL_POS] == $past(sdata))
      else $error("shift register missed a serial bit");

   load_seq_a:
      assert property (@(posedge clk) disable iff (!nrst)
         $rose(s.ls_s2) && s.armed ##1 s.ls_s2 |=> s.st == synth_pkg::ST_COPY)
      else $error("strobe high did not reach the copy state");

   ref_load_a:
      assert property (@(posedge clk) disable iff (!nrst)
         s.st == synth_pkg::ST_COPY && s.ls_s2 && lk.sr[`CTL_POS]
         |=> s.r == $past(lk.sr[`REF_FRAME-1:`R_LSB])
            && s.sw == $past(lk.sr[`SW_POS]) && $stable(s.n) && $stable(s.a))
      else $error("reference load wrong or touched main latch");

   main_load_a:
      assert property (@(posedge clk) disable iff (!nrst)
         s.st == synth_pkg::ST_COPY && s.ls_s2 && !lk.sr[`CTL_POS]
         |=> s.n == $past(lk.sr[`N_LSB+`N_W-1:`N_LSB])
            && s.a == $past(lk.sr[`A_LSB+`A_W-1:`A_LSB])
            && $stable(s.r) && $stable(s.sw))
      else $error("main load wrong or touched reference latch");

   latch_hold_a:
      assert property (@(posedge clk) disable iff (!nrst)
         !s.ls_s2 |=> $stable(s.r) && $stable(s.sw) && $stable(s.n) && $stable(s.a))
      else $error("a latch changed while the strobe was low");

   copy_gate_a:
      assert property (@(posedge clk) disable iff (!nrst)
         s.st == synth_pkg::ST_COPY |-> $past(s.ls_s2))
      else $error("copy state reached without a high strobe");

   aux_switch_a:
      assert property (@(posedge clk) disable iff (!nrst)
         1'b1 ##1 1'b1 |-> s.aux_oe_n == !$past(s.ls_s2) && s.aux == s.pu)
      else $error("switch pin drive does not follow the strobe");

   monitor_sel_a:
      assert property (@(posedge clk) disable iff (!nrst)
         1'b1 ##1 1'b1 |-> s.mon == ($past(s.ps_s2) ? $past(s.rp) : $past(main_pulse)))
      else $error("monitor output shows the wrong divider");

   sense_flip_a:
      assert property (@(posedge clk) disable iff (!nrst)
         !s.ps_s2 && s.up && !s.dn |=> s.pd && !s.pu && s.phr && s.php)
      else $error("low phase select did not reverse the sense");

   sense_norm_a:
      assert property (@(posedge clk) disable iff (!nrst)
         s.ps_s2 && s.up && !s.dn |=> s.pu && !s.pd && !s.phr && !s.php)
      else $error("high phase select did not keep the normal sense");

   pullup_rst_a:
      assert property (@(posedge clk) disable iff (!nrst)
         $rose(nrst) |-> s.ls_s2 && s.ps_s2 && s.aux_oe_n)
      else $error("open inputs do not read high after reset");

   frame_gate_a:
      assert property (@(posedge clk) disable iff (!nrst)
         !s.armed |-> s.st == synth_pkg::ST_IDLE)
      else $error("latch load without a prior low strobe");

   ref_load_cov: cover property (@(posedge clk) disable iff (!nrst)
      s.st == synth_pkg::ST_COPY && s.ls_s2 && lk.sr[`CTL_POS]);
   main_load_cov: cover property (@(posedge clk) disable iff (!nrst)
      s.st == synth_pkg::ST_COPY && s.ls_s2 && !lk.sr[`CTL_POS]);
   rev_sense_cov: cover property (@(posedge clk) disable iff (!nrst)
      !s.ps_s2 && s.pu);
   monitor_cov: cover property (@(posedge clk) disable iff (!nrst)
      s.mon && !s.ps_s2);
endmodule // synth_serial_program_latches

// ### tb/serial_ctrl_model.sv
// controller model for the three-wire link: shifts a frame msb first, then pulses the strobe
// assumes the bench calls send hierarchically; link clock period 48 ns, free of clk phase
`timescale 1ns/1ps
module serial_ctrl_model
(
   output logic sclk, // shift clock, still outside frames
   output logic sdata, // serial data
   output logic load_strobe // load strobe, high while undriven at start
);
   initial
   begin
      sclk = 1'b0;
      sdata = 1'b0;
      load_strobe = 1'b1;
   end

   task automatic send(input logic [18:0] frame, input int len);
      int i;
      load_strobe = 1'b0;
      #37;
      for (i = len - 1; i >= 0; i--)
      begin
         sdata = frame[i];
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      // hold time over: data no longer shows the last bit
      sdata = ~sdata;
      #30 load_strobe = 1'b1;
      #200 load_strobe = 1'b0;
      #100;
   endtask
endmodule // serial_ctrl_model

// ### tb/test_synth_serial_program_latches.sv
// self-checking bench of the serial program latches: frames, latches, monitor, switch pin
// assumes serial_ctrl_model drives the link and the register port is plain strobes
`timescale 1ns/1ps
module test_synth_serial_program_latches;
   logic clk, nrst, sclk, sdata, load_strobe, phase_sense_select, wr, rd;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic mon, phr, php, pup, pdn, aux, aux_oe_n;
   int fail_count, n_compared;

   serial_ctrl_model link (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));

   synth_serial_program_latches dut
   (
      .clk(clk), .nrst(nrst), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
      .phase_sense_select(phase_sense_select), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .comparator_monitor_out(mon), .phase_r_out(phr),
      .phase_p_out(php), .pump_up_out(pup), .pump_dn_out(pdn),
      .aux_pump_switch_out(aux), .aux_pump_switch_oe_n(aux_oe_n)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         fail_count++;
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   task automatic set_select(input logic v);
      @(posedge clk);
      phase_sense_select <= v;
      repeat (6) tick();
   endtask

   // distance between the second and third monitor pulses, so a reload settles first
   task automatic period_check(input int exp);
      int n;
      n = 0;
      repeat (3)
      begin
         n = 0;
         do
         begin
            tick();
            n++;
         end while (mon !== 1'b1 && n < 9000);
      end
      if (n >= 9000)
      begin
         fail_count++;
         conclude();
      end
      check(n, exp);
   endtask

   task automatic s_reset();
      rd_check(4'h0, 32'h0000_0001);
      rd_check(4'h4, 32'h0000_0008);
      rd_check(4'h8, 32'h0000_0800);
      period_check(8);
      set_select(1'b0);
      period_check(1024);
      $display("reset values and monitor source done");
   endtask

   task automatic s_regs();
      int hits;
      set_select(1'b1);
      wr_reg(4'h0, 32'h0000_0000);
      rd_check(4'h0, 32'h0000_0000);
      hits = 0;
      repeat (100)
      begin
         tick();
         if (mon === 1'b1)
            hits++;
      end
      check(hits, 0);
      check({pup, pdn, phr, php, aux}, 5'h02);
      wr_reg(4'h0, 32'h0000_0001);
      // reference pulse nine cycles after enable leads the main one, so up stays set
      repeat (20) tick();
      check({pup, pdn, phr, php, aux}, 5'h11);
      rd_check(4'hc, 32'h0000_000d);
      set_select(1'b0);
      check({pup, pdn, phr, php, aux}, 5'h0e);
      set_select(1'b1);
      wr_reg(4'h4, 32'h0000_0005);
      rd_check(4'h4, 32'h0000_0008);
      rd_check(4'h2, 32'h0000_0000);
      period_check(8);
      $display("register port done");
   endtask

   task automatic s_ref();
      int n;
      set_select(1'b0);
      fork
         link.send({3'h0, 14'h0014, 1'b1, 1'b1}, 16);
         begin
            repeat (5) tick();
            check(aux_oe_n, 1'b1);
            n = 0;
            while (load_strobe !== 1'b1 && n < 200)
            begin
               tick();
               n++;
            end
            if (n >= 200)
            begin
               fail_count++;
               conclude();
            end
            repeat (5) tick();
            check(aux_oe_n, 1'b0);
         end
      join
      repeat (5) tick();
      check(aux_oe_n, 1'b1);
      rd_check(4'h4, 32'h0000_4014);
      rd_check(4'h8, 32'h0000_0800);
      period_check(512);
      set_select(1'b1);
      period_check(20);
      $display("reference frame done");
   endtask

   task automatic s_main();
      link.send({11'h011, 7'h03, 1'b0}, 19);
      rd_check(4'h8, 32'h0000_0883);
      rd_check(4'h4, 32'h0000_4014);
      set_select(1'b0);
      period_check(547);
      $display("main frame done");
   endtask

   initial
   begin
      nrst = 1'b0;
      phase_sense_select = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      fail_count = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      s_reset();
      s_regs();
      s_ref();
      s_main();
      conclude();
   end
endmodule // test_synth_serial_program_latches
